/* core/qks_knob_step.sv */
`timescale 1ns/1ps
`include "qks_defs.svh"
// Function
// - each encoder input is averaged over a window tolerating about 3 ms bounce
// - averaged value meets two thresholds; a timer accepts only stable levels
// - direction comes from which input changed, how, and the other's level
// - first phase leading second phase means up; opposite order means down
// - emitted sequence depends only on direction and store-request level
// - decode rate only decides launches, never sequence shape or timing
// - every output transition sits on a 200 us time step
// - up/down set by select fall, then one low-to-high count edge
// - store request high keeps up/down high while select returns high
// - changes on only one input are never taken as rotation
// - fast rate gives four sequences per cycle, slow rate gives two
// - a launch needs a change on one input followed by the other
// - a launch arriving while a sequence runs is dropped
// - after reset outputs sit quiescent and hold still for 50 ms
module qks_knob_step import qks_pkg::*; #(
  parameter int STEP_CYC = `QKS_STEP_CYC,
  parameter int SAMPLE_CYC = `QKS_SAMPLE_CYC,
  parameter int STABLE_CYC = `QKS_STABLE_CYC,
  parameter int STARTUP_CYC = `QKS_STARTUP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_store_req,
  input wire logic i_decode_rate_sel,
  output logic o_sel_n,
  output logic o_up_dn
);
  localparam int PW = $clog2(STEP_CYC);
  localparam int UW = $clog2(STARTUP_CYC + 1);
  localparam logic [PW-1:0] STEP_LAST = PW'(STEP_CYC - 1);
  localparam logic [UW-1:0] STARTUP_LAST = UW'(STARTUP_CYC - 1);

  if (STEP_CYC < 2 || STARTUP_CYC < 2) begin : g_bad
    $error("qks_knob_step: step and startup counts must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input cleaning, one cleaner per encoder phase

  logic [1:0] pins;
  logic [1:0] lvl;
  logic [1:0] chg;

  assign pins = {i_enc_b, i_enc_a};

  for (genvar g = 0; g < 2; g++) begin : g_ch
    qks_clean_if cif ();
    assign cif.raw = pins[g];
    qks_cleaner #(
      .SAMPLE_CYC(SAMPLE_CYC),
      .STABLE_CYC(STABLE_CYC)
    ) u_clean (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .cif(cif.cleaner)
    );
    assign lvl[g] = cif.level;
    assign chg[g] = cif.chg;
  end

  // control pins come from outside, so they cross two flops first
  logic store_s1_r, store_s2_r, rate_s1_r, rate_s2_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      store_s1_r <= 1'h0;
      store_s2_r <= 1'h0;
      rate_s1_r <= 1'h0;
      rate_s2_r <= 1'h0;
    end else begin
      store_s1_r <= i_store_req;
      store_s2_r <= store_s1_r;
      rate_s1_r <= i_decode_rate_sel;
      rate_s2_r <= rate_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // startup hold

  logic [UW-1:0] start_cnt_r;
  logic ready_r;

  // counts out the hold once; outputs stay quiescent until ready_r
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      start_cnt_r <= '0;
      ready_r <= 1'h0;
    end else if (!ready_r) begin
      if (start_cnt_r == STARTUP_LAST) ready_r <= 1'h1;
      else start_cnt_r <= start_cnt_r + 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction and launch decision

  logic last_vld_r;
  logic last_ch_r;
  logic want;
  logic want_up;

  // a launch needs the other phase to have moved last; a lone phase
  // chattering back and forth only keeps re-marking itself
  always_comb begin
    want = 1'h0;
    want_up = 1'h0;
    if (chg[0] && !chg[1]) begin
      want = last_vld_r && last_ch_r;
      want_up = lvl[0] != lvl[1];
    end else if (chg[1] && !chg[0]) begin
      want = last_vld_r && !last_ch_r && rate_s2_r;
      want_up = lvl[1] == lvl[0];
    end
  end

  // remember which phase changed last; a simultaneous change is ambiguous
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      last_vld_r <= 1'h0;
      last_ch_r <= 1'h0;
    end else if (chg[0] && chg[1]) begin
      last_vld_r <= 1'h0;
    end else if (chg[0] || chg[1]) begin
      last_vld_r <= 1'h1;
      last_ch_r <= chg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output sequencer

  qks_state_t state_r, state_nxt;
  logic [PW-1:0] step_r;
  logic step_done;
  logic launch;
  logic dir_r, store_r;

  assign step_done = step_r == STEP_LAST;
  // busy sequencer or startup hold drops the launch instead of queueing it
  assign launch = want && ready_r && state_r == QKS_ST_IDLE;

  // each sequence state from SETUP to REL lasts exactly one time step; WAIT and IDLE last until they are left
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      QKS_ST_WAIT: if (ready_r) state_nxt = QKS_ST_IDLE;
      QKS_ST_IDLE: if (launch) state_nxt = QKS_ST_SETUP;
      QKS_ST_SETUP: if (step_done) state_nxt = QKS_ST_SEL;
      QKS_ST_SEL: if (step_done) state_nxt = dir_r ? QKS_ST_LOW : QKS_ST_CNT;
      QKS_ST_LOW: if (step_done) state_nxt = QKS_ST_CNT;
      QKS_ST_CNT: if (step_done) state_nxt = QKS_ST_END;
      QKS_ST_END: if (step_done) state_nxt = QKS_ST_REL;
      QKS_ST_REL: if (step_done) state_nxt = QKS_ST_IDLE;
      default: state_nxt = QKS_ST_WAIT;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) state_r <= QKS_ST_WAIT;
    else state_r <= state_nxt;
  end

  // step timer restarts on every state change; idle never counts
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) step_r <= '0;
    else if (state_nxt != state_r || state_r == QKS_ST_IDLE) step_r <= '0;
    else step_r <= step_r + 1'h1;
  end

  // direction and store level are frozen at launch, so a pin moving
  // mid-sequence cannot bend the waveform
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dir_r <= 1'h0;
      store_r <= 1'h0;
    end else if (launch) begin
      dir_r <= want_up;
      store_r <= store_s2_r;
    end
  end

  // outputs decoded from the next state and registered
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_sel_n <= 1'h1;
      o_up_dn <= 1'h0;
    end else begin
      case (state_nxt)
        QKS_ST_SETUP: begin
          o_sel_n <= 1'h1;
          o_up_dn <= dir_nxt_sel(launch, want_up, dir_r);
        end
        QKS_ST_SEL: begin
          o_sel_n <= 1'h0;
          o_up_dn <= dir_r;
        end
        QKS_ST_LOW: begin
          o_sel_n <= 1'h0;
          o_up_dn <= 1'h0;
        end
        QKS_ST_CNT: begin
          o_sel_n <= 1'h0;
          o_up_dn <= 1'h1;
        end
        QKS_ST_END: begin
          o_sel_n <= 1'h0;
          o_up_dn <= store_r;
        end
        QKS_ST_REL: begin
          o_sel_n <= 1'h1;
          o_up_dn <= store_r;
        end
        default: begin
          o_sel_n <= 1'h1;
          o_up_dn <= 1'h0;
        end
      endcase
    end
  end

  // in the launch cycle dir_r is not loaded yet, so take the fresh value
  function automatic logic dir_nxt_sel(input logic l, input logic fresh, input logic held);
    dir_nxt_sel = l ? fresh : held;
  endfunction : dir_nxt_sel

endmodule : qks_knob_step

/* core/qks_defs.svh */
`ifndef QKS_DEFS_SVH
`define QKS_DEFS_SVH

// master clock rate
`define QKS_CLK_HZ 20000000
// basic output time step
`define QKS_STEP_US 200
`define QKS_STEP_CYC ((`QKS_STEP_US * (`QKS_CLK_HZ / 1000000)))
// averaging filter sample interval
`define QKS_SAMPLE_US 100
`define QKS_SAMPLE_CYC ((`QKS_SAMPLE_US * (`QKS_CLK_HZ / 1000000)))
// filter accumulator range and hysteresis thresholds
`define QKS_ACC_MAX 31
`define QKS_ACC_HI 24
`define QKS_ACC_LO 8
// stability timer period after the comparators
`define QKS_STABLE_US 2000
`define QKS_STABLE_CYC ((`QKS_STABLE_US * (`QKS_CLK_HZ / 1000000)))
// startup hold after reset release
`define QKS_STARTUP_MS 50
`define QKS_STARTUP_CYC ((`QKS_STARTUP_MS * (`QKS_CLK_HZ / 1000)))
// reset level of a cleaned input (encoder pullups)
`define QKS_CLEAN_RST 1'h1

`endif

/* core/qks_pkg.sv */
package qks_pkg;

  // output sequencer states
  typedef enum logic [2:0] {
    QKS_ST_WAIT  = 3'h0,
    QKS_ST_IDLE  = 3'h1,
    QKS_ST_SETUP = 3'h2,
    QKS_ST_SEL   = 3'h3,
    QKS_ST_LOW   = 3'h4,
    QKS_ST_CNT   = 3'h5,
    QKS_ST_END   = 3'h6,
    QKS_ST_REL   = 3'h7
  } qks_state_t;

endpackage : qks_pkg

/* core/qks_clean_if.sv */
`timescale 1ns/1ps
// one encoder channel: raw pin level in, cleaned level and change pulse out
interface qks_clean_if;
  logic raw;
  logic level;
  logic chg;
  modport cleaner (input raw, output level, output chg);
  modport user (output raw, input level, input chg);
endinterface : qks_clean_if

/* core/qks_cleaner.sv */
`timescale 1ns/1ps
`include "qks_defs.svh"
module qks_cleaner import qks_pkg::*; #(
  parameter int SAMPLE_CYC = `QKS_SAMPLE_CYC,
  parameter int STABLE_CYC = `QKS_STABLE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  qks_clean_if.cleaner cif
);
  localparam int TW = $clog2(SAMPLE_CYC);
  localparam int SW = $clog2(STABLE_CYC);
  localparam logic [TW-1:0] TICK_LAST = TW'(SAMPLE_CYC - 1);
  localparam logic [SW-1:0] STABLE_LAST = SW'(STABLE_CYC - 1);
  localparam logic [4:0] ACC_MAX = 5'(`QKS_ACC_MAX);
  localparam logic [4:0] ACC_HI = 5'(`QKS_ACC_HI);
  localparam logic [4:0] ACC_LO = 5'(`QKS_ACC_LO);

  if (SAMPLE_CYC < 2 || STABLE_CYC < 2) begin : g_bad
    $error("qks_cleaner: sample and stable counts must be at least 2");
  end

  logic s1_r, s2_r;
  logic [TW-1:0] tick_r;
  logic [4:0] acc_r;
  logic cmp_r, level_r, chg_r;
  logic [SW-1:0] stab_r;

  // two-flop synchroniser, only s2_r is read beyond it
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= `QKS_CLEAN_RST;
      s2_r <= `QKS_CLEAN_RST;
    end else begin
      s1_r <= cif.raw;
      s2_r <= s1_r;
    end
  end

  // sample tick; averaging window is acc range times tick
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) tick_r <= '0;
    else if (tick_r == TICK_LAST) tick_r <= '0;
    else tick_r <= tick_r + 1'h1;
  end

  // saturating up/down integrator: short bounces barely move the average
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      acc_r <= ACC_MAX;
    end else if (tick_r == TICK_LAST) begin
      if (s2_r && acc_r != ACC_MAX) acc_r <= acc_r + 5'h1;
      else if (!s2_r && acc_r != 5'h0) acc_r <= acc_r - 5'h1;
    end
  end

  // two thresholds give hysteresis; between them the comparator holds
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) cmp_r <= `QKS_CLEAN_RST;
    else if (acc_r >= ACC_HI) cmp_r <= 1'h1;
    else if (acc_r <= ACC_LO) cmp_r <= 1'h0;
  end

  // stability timer: a new level is taken only after it held a full period
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      stab_r <= '0;
      level_r <= `QKS_CLEAN_RST;
      chg_r <= 1'h0;
    end else begin
      chg_r <= 1'h0;
      if (cmp_r == level_r) begin
        stab_r <= '0;
      end else if (stab_r == STABLE_LAST) begin
        stab_r <= '0;
        level_r <= cmp_r;
        chg_r <= 1'h1;
      end else begin
        stab_r <= stab_r + 1'h1;
      end
    end
  end

  assign cif.level = level_r;
  assign cif.chg = chg_r;

endmodule : qks_cleaner

/* tb/qks_knob_step_chk.sv */
`timescale 1ns/1ps
// pin-level watcher for the knob step decoder
module qks_knob_step_chk #(
  parameter int STEP_CYC = 8,
  parameter int STARTUP_CYC = 50
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_store_req,
  input wire logic i_decode_rate_sel,
  input wire logic o_sel_n,
  input wire logic o_up_dn
);
  logic sel_q_r, ud_q_r;
  logic [15:0] age_r, low_r;
  logic [1:0] rise_r;
  logic [31:0] boot_r;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  // age of last output move, select-low span, count edges, time since reset;
  // age and boot counters saturate so a long idle never wraps into a false match
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sel_q_r <= 1'h1;
      ud_q_r <= 1'h0;
      age_r <= 16'h0;
      low_r <= 16'h0;
      rise_r <= 2'h0;
      boot_r <= 32'h0;
    end else begin
      sel_q_r <= o_sel_n;
      ud_q_r <= o_up_dn;
      if (o_sel_n != sel_q_r || o_up_dn != ud_q_r) age_r <= 16'h1;
      else if (age_r != 16'hFFFF) age_r <= age_r + 16'h1;
      low_r <= o_sel_n ? 16'h0 : low_r + 16'h1;
      rise_r <= o_sel_n ? 2'h0 : rise_r + 2'(o_up_dn && !ud_q_r);
      if (boot_r != 32'hFFFFFFFF) boot_r <= boot_r + 32'h1;
    end
  end
  ////////////////////////////////////////
  a_step_grid: assert property (
    (!$stable(o_sel_n) || !$stable(o_up_dn)) && !$past(o_sel_n)
      |-> (age_r == STEP_CYC || age_r == 2 * STEP_CYC))
    else $error("output moved off the step grid");
  a_dir_before_sel: assert property (
    $fell(o_sel_n) |-> $stable(o_up_dn) && age_r >= STEP_CYC)
    else $error("up/down not settled a step before select fall");
  a_one_count_edge: assert property (
    $rose(o_sel_n) |-> rise_r == 2'h1)
    else $error("select low without exactly one count edge");
  a_store_high: assert property (
    $rose(o_sel_n) && i_store_req |-> $past(o_up_dn) && o_up_dn)
    else $error("store asked but up/down low at select rise");
  a_store_low: assert property (
    $rose(o_sel_n) && !i_store_req |-> !$past(o_up_dn))
    else $error("up/down high at select rise without store");
  a_idle_ud_low: assert property (
    $rose(o_sel_n) |-> ##[0:STEP_CYC] !o_up_dn)
    else $error("up/down did not return to idle low");
  // holds for any step of eight cycles or more
  a_idle_sel_gap: assert property (
    $rose(o_sel_n) |-> o_sel_n [*8])
    else $error("select fell again too soon");
  a_sel_low_span: assert property (
    $rose(o_sel_n) |-> (low_r == 3 * STEP_CYC || low_r == 4 * STEP_CYC))
    else $error("select low span is not a whole sequence");
  a_startup_quiet: assert property (
    boot_r < STARTUP_CYC |-> o_sel_n && !o_up_dn)
    else $error("output moved during startup hold");
  c_up_step: cover property ($fell(o_sel_n) && o_up_dn);
  c_down_step: cover property ($fell(o_sel_n) && !o_up_dn);
  c_store: cover property ($rose(o_sel_n) && o_up_dn);
  c_slow_rate: cover property ($fell(o_sel_n) && !i_decode_rate_sel);
endmodule : qks_knob_step_chk

/* tb/qks_pot_model.sv */
`timescale 1ns/1ps
// counting pot: mode taken at select fall, counts on up/down rise
module qks_pot_model (
  input wire logic i_mclk,
  input wire logic i_sel_n,
  input wire logic i_up_dn,
  output int o_count,
  output int o_stores
);
  logic sel_q_r = 1'h1;
  logic ud_q_r = 1'h0;
  logic up_r = 1'h0;
  // a store is taken when select rises while up/down is high
  always_ff @(posedge i_mclk) begin
    sel_q_r <= i_sel_n;
    ud_q_r <= i_up_dn;
    if (sel_q_r && !i_sel_n) up_r <= i_up_dn;
    if (!i_sel_n && !sel_q_r && i_up_dn && !ud_q_r) o_count <= o_count + (up_r ? 1 : -1);
    if (i_sel_n && !sel_q_r && i_up_dn) o_stores <= o_stores + 1;
  end
endmodule : qks_pot_model

/* tb/qks_knob_step_test.sv */
`timescale 1ns/1ps
// knob decoder bench; the pot model tallies what the outputs command
module qks_knob_step_test;
  localparam int STEP = 8;
  localparam int BOOT = 50;
  localparam int HOLD = 260;
  localparam int LIMIT = 30000;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic enc_a = 1'h1;
  logic enc_b = 1'h1;
  logic store = 1'h0;
  logic rate = 1'h1;
  logic sel_n, up_dn;
  bit drop = 1'h0;
  int count, stores;
  int exp_count = 0;
  int exp_stores = 0;
  int last_ph = 2;
  int seed = 32'h230a;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  qks_knob_step #(.STEP_CYC(STEP), .SAMPLE_CYC(4), .STABLE_CYC(16), .STARTUP_CYC(BOOT)) dut (
    .i_mclk(clk), .i_rst(rst), .i_enc_a(enc_a), .i_enc_b(enc_b), .i_store_req(store),
    .i_decode_rate_sel(rate), .o_sel_n(sel_n), .o_up_dn(up_dn));
  qks_pot_model pot (.i_mclk(clk), .i_sel_n(sel_n), .i_up_dn(up_dn), .o_count(count),
    .o_stores(stores));

  always #25 clk = ~clk;

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // no launch when nothing or the same phase moved last, nor for phase b at 2x
  function automatic int step_val(input bit ph_b, input bit a_n, input bit b_n, input bit rt);
    bit up;
    up = ph_b ? (b_n == a_n) : (a_n != b_n);
    if (last_ph == 2 || last_ph == int'(ph_b) || (ph_b && !rt)) return 0;
    return up ? 1 : -1;
  endfunction : step_val

  // one phase change with contact bounce; a short gap lets the next change
  // land while the sequence still runs
  task automatic move(input bit ph_b, input bit st, input bit rt, input int gap);
    int d;
    int bnc;
    bit a_n, b_n;
    a_n = enc_a ^ !ph_b;
    b_n = enc_b ^ ph_b;
    d = drop ? 0 : step_val(ph_b, a_n, b_n, rt);
    // the race case runs bounce-free, so its clean change lands within a few
    // cycles of a known time and surely inside the running sequence
    bnc = (drop || gap < HOLD) ? 0 : $random(seed) & 15;
    drop = 1'h0;
    @(posedge clk);
    store <= st;
    rate <= rt;
    repeat (4) @(posedge clk);
    repeat (bnc) begin
      @(posedge clk);
      if (ph_b) enc_b <= ~enc_b;
      else enc_a <= ~enc_a;
    end
    @(posedge clk);
    enc_a <= a_n;
    enc_b <= b_n;
    last_ph = ph_b;
    exp_count += d;
    if (d != 0 && st) exp_stores++;
    repeat (gap) @(posedge clk);
    if (gap >= HOLD) begin
      chk(count, exp_count);
      chk(stores, exp_stores);
    end
  endtask : move

  ////////////////////////////////////////
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (BOOT - 10) @(posedge clk);
    chk({sel_n, up_dn}, 32'h2);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 8; i++) move(i[0] ^ (i >= 4), 1'h0, 1'h1, HOLD);
    for (int i = 0; i < 5; i++) move(i[0], 1'h0, 1'h0, HOLD);
    move(1'h1, 1'h1, 1'h1, HOLD);
    move(1'h0, 1'h1, 1'h1, HOLD);
    repeat (3) move(1'h0, 1'h0, 1'h1, HOLD);
    for (int i = 0; i < 30; i++) begin
      move(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), HOLD);
    end
    move(1'h1, 1'h0, 1'h1, HOLD);
    move(1'h0, 1'h0, 1'h1, 20);
    drop = 1'h1;
    move(1'h1, 1'h0, 1'h1, HOLD);
    conclude();
  end
endmodule : qks_knob_step_test

bind qks_knob_step qks_knob_step_chk #(.STEP_CYC(STEP_CYC), .STARTUP_CYC(STARTUP_CYC)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_enc_a(i_enc_a), .i_enc_b(i_enc_b),
  .i_store_req(i_store_req), .i_decode_rate_sel(i_decode_rate_sel),
  .o_sel_n(o_sel_n), .o_up_dn(o_up_dn));
